// ===== ciq_top.sv
// Contract
// - Software enables each source (error and every buffer) separately for code encoding.
// - Enable bit 15 includes a pending error in the encoded code when 1 and excludes it when 0.
// - Enable bits 14 to 0 include the matching buffer's pending flag when 1, exclude it when 0.
// - Node state reads 000 inactive, 010 active, 011 warning, 10X passive and 11X bus off.
// - The request flag and source code name the top source that is pending and enabled.
// - The code is 0000 for none or error and 0001 to 1111 for buffers 0 to 14.
// - A buffer's pending flag is set after a successful transfer through that buffer.
// - The error pending flag sets on an error status change and clears on a written 1.
//
// Design decisions made here: the plain strobed port and the register addresses.
module ciq_top (
  // Clock and reset
  input  logic                  clk,
  input  logic                  reset,
  // Register port
  input  ciq_pkg::ciq_bus_req_t bus_req,
  output logic [15:0]           rd_data,
  // Protocol engine events and node state
  input  ciq_pkg::ciq_can_evt_t can_evt,
  input  ciq_pkg::ciq_node_in_t node_in,
  // Interrupt
  output logic                  irq
);

  import ciq_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  ciq_state_t         state_q;
  ciq_state_t         state_d;
  logic               wr_code_en;
  logic               wr_clear;
  logic               wr_int_stat;
  logic               wr_int_mask;
  logic [DATA_W-1:0]  pend_set;
  logic [DATA_W-1:0]  pend_clr;
  logic [DATA_W-1:0]  pending;
  logic [DATA_W-1:0]  active;
  logic               enc_flag;
  logic [CODE_W-1:0]  enc_code;
  logic [NS_W-1:0]    ns_now;
  logic [NUM_INT-1:0] int_set;
  logic [NUM_INT-1:0] int_clr;
  logic [NUM_INT-1:0] int_stat;
  logic [DATA_W-1:0]  status_word;

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  assign wr_code_en  = bus_req.wr && (bus_req.addr == OFS_CODE_EN);
  assign wr_clear    = bus_req.wr && (bus_req.addr == OFS_CLEAR);
  assign wr_int_stat = bus_req.wr && (bus_req.addr == OFS_INT_STAT);
  assign wr_int_mask = bus_req.wr && (bus_req.addr == OFS_INT_MASK);

  // ---------------------------------------------------------------
  // Pending flags
  // ---------------------------------------------------------------
  // error change and buffer transfer set
  assign pend_set = {can_evt.error_change, can_evt.buffer_done};

  assign pend_clr = wr_clear ? bus_req.wdata : '0;

  ciq_sticky #(
    .W (DATA_W)
  ) u_pending (
    .clk   (clk),
    .reset (reset),
    .set   (pend_set),
    .clr   (pend_clr),
    .q     (pending)
  );

  // ---------------------------------------------------------------
  // Interrupt code
  // ---------------------------------------------------------------
  // per source gating
  assign active = pending & state_q.code_en;

  ciq_prio_enc #(
    .NBUF (NUM_BUF),
    .CW   (CODE_W)
  ) u_enc (
    .err_act (active[ERR_BIT]),
    .buf_act (active[NUM_BUF-1:0]),
    .flag    (enc_flag),
    .code    (enc_code)
  );

  // ---------------------------------------------------------------
  // Node state
  // ---------------------------------------------------------------
  // node state encoding
  always_comb begin
    if (node_in.bus_off) begin
      ns_now = NS_BUS_OFF;
    end else if (node_in.passive) begin
      ns_now = NS_PASSIVE;
    end else if (node_in.warning) begin
      ns_now = NS_WARNING;
    end else if (node_in.active) begin
      ns_now = NS_ACTIVE;
    end else begin
      ns_now = NS_INACTIVE;
    end
  end

  // ---------------------------------------------------------------
  // Event interrupts
  // ---------------------------------------------------------------
  // Events are raised on the set pulse itself, so a flag cleared and set
  // in one cycle still interrupts the CPU.
  always_comb begin
    int_set          = '0;
    int_set[INT_ERR] = can_evt.error_change;
    int_set[INT_BUF] = |can_evt.buffer_done;
    int_set[INT_NS]  = (ns_now != state_q.node_state);
  end

  assign int_clr = wr_int_stat ? bus_req.wdata[NUM_INT-1:0] : '0;

  ciq_sticky #(
    .W (NUM_INT)
  ) u_int_stat (
    .clk   (clk),
    .reset (reset),
    .set   (int_set),
    .clr   (int_clr),
    .q     (int_stat)
  );

  // ---------------------------------------------------------------
  // Status word and next state
  // ---------------------------------------------------------------
  // The code lags the pending flags by one cycle because it is registered;
  // this keeps the read path short at the cost of one cycle of latency.
  always_comb begin
    status_word                                = '0;
    status_word[NS_LSB+NS_W-1:NS_LSB]          = state_q.node_state;
    status_word[IRQ_BIT]                       = state_q.irq_flag;
    status_word[CODE_W-1:0]                    = state_q.irq_code;
  end

  always_comb begin
    state_d            = state_q;
    state_d.node_state = ns_now;
    state_d.irq_flag   = enc_flag;
    state_d.irq_code   = enc_code;
    if (wr_code_en) begin
      state_d.code_en = bus_req.wdata;
    end
    if (wr_int_mask) begin
      state_d.int_mask = bus_req.wdata[NUM_INT-1:0];
    end
    // Unmapped and write-only addresses read as zero.
    state_d.rd_data = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_CODE_EN:  state_d.rd_data = state_q.code_en;
        OFS_STATUS:   state_d.rd_data = status_word;
        OFS_PENDING:  state_d.rd_data = pending;
        OFS_INT_STAT: state_d.rd_data = DATA_W'(int_stat);
        OFS_INT_MASK: state_d.rd_data = DATA_W'(state_q.int_mask);
        default:      state_d.rd_data = '0;
      endcase
    end
    state_d.irq = |(int_stat & state_q.int_mask);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q            <= '0;
      state_q.code_en    <= CODE_EN_RST;
      state_q.int_mask   <= INT_MASK_RST;
      state_q.node_state <= NS_INACTIVE;
      state_q.irq_code   <= CODE_NONE;
    end else begin
      state_q <= state_d;
    end
  end

  assign rd_data = state_q.rd_data;
  assign irq     = state_q.irq;

endmodule // ciq_top

// ===== ciq_pkg.sv
package ciq_pkg;

  // ---------------------------------------------------------------
  // Bus and data widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned NUM_BUF  = 15;
  localparam int unsigned CODE_W   = 4;
  localparam int unsigned NS_W     = 3;
  localparam int unsigned NUM_INT  = 3;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CODE_EN  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PENDING  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CLEAR    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h14;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned ERR_BIT    = 15;
  localparam int unsigned NS_LSB     = 8;
  localparam int unsigned IRQ_BIT    = 4;
  localparam int unsigned INT_ERR    = 0;
  localparam int unsigned INT_BUF    = 1;
  localparam int unsigned INT_NS     = 2;

  // ---------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0]  CODE_EN_RST  = 16'h0000;
  localparam logic [NUM_INT-1:0] INT_MASK_RST = 3'h0;
  localparam logic [CODE_W-1:0]  CODE_NONE    = 4'h0;
  localparam logic [NS_W-1:0]    NS_INACTIVE  = 3'h0;
  localparam logic [NS_W-1:0]    NS_ACTIVE    = 3'h2;
  localparam logic [NS_W-1:0]    NS_WARNING   = 3'h3;
  localparam logic [NS_W-1:0]    NS_PASSIVE   = 3'h4;
  localparam logic [NS_W-1:0]    NS_BUS_OFF   = 3'h6;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ciq_bus_req_t;

  typedef struct packed {
    logic               error_change;
    logic [NUM_BUF-1:0] buffer_done;
  } ciq_can_evt_t;

  typedef struct packed {
    logic active;
    logic warning;
    logic passive;
    logic bus_off;
  } ciq_node_in_t;

  typedef struct packed {
    logic [DATA_W-1:0]  code_en;
    logic [NUM_INT-1:0] int_mask;
    logic [NS_W-1:0]    node_state;
    logic               irq_flag;
    logic [CODE_W-1:0]  irq_code;
    logic [DATA_W-1:0]  rd_data;
    logic               irq;
  } ciq_state_t;

endpackage

// ===== ciq_sticky.sv
// Bank of sticky flags; a set in the same cycle as a clear wins.
module ciq_sticky #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input  logic         clk,
  input  logic         reset,
  // Set and clear pulses
  input  logic [W-1:0] set,
  input  logic [W-1:0] clr,
  // Flags
  output logic [W-1:0] q
);

  logic [W-1:0] flags_q;
  logic [W-1:0] flags_d;

  always_comb begin
    flags_d = (flags_q & ~clr) | set;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign q = flags_q;

endmodule // ciq_sticky

// ===== ciq_prio_enc.sv
// Picks the highest-priority source among those pending and enabled.
module ciq_prio_enc #(
  parameter int unsigned NBUF  = 15,
  parameter int unsigned CW    = 4
) (
  // Sources
  input  logic            err_act,
  input  logic [NBUF-1:0] buf_act,
  // Result
  output logic            flag,
  output logic [CW-1:0]   code
);

  always_comb begin
    code = '0;
    // Scan downward so the lowest buffer number is the last to win.
    for (int i = NBUF - 1; i >= 0; i--) begin
      if (buf_act[i]) begin
        code = CW'(i + 1);
      end
    end
    if (err_act) begin
      code = '0;
    end
    flag = err_act | (|buf_act);
  end

endmodule // ciq_prio_enc

// ===== ciq_top_asserts.sv
module ciq_top_asserts (
  // Clock and reset
  input logic                  clk,
  input logic                  reset,
  // Watched ports
  input ciq_pkg::ciq_bus_req_t bus_req,
  input logic [15:0]           rd_data,
  input ciq_pkg::ciq_can_evt_t can_evt,
  input ciq_pkg::ciq_node_in_t node_in,
  input logic                  irq
);
  import ciq_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_code_en_back:
    assert property ((bus_req.wr && bus_req.addr == OFS_CODE_EN) ##1 !bus_req.wr
      ##1 (bus_req.rd && bus_req.addr == OFS_CODE_EN) |=> rd_data == $past(bus_req.wdata, 3))
    else $error("code enable readback wrong");
  a_none_enabled:
    assert property ((bus_req.wr && bus_req.addr == OFS_CODE_EN && bus_req.wdata == 16'h0000)
      ##1 !bus_req.wr ##1 (bus_req.rd && bus_req.addr == OFS_STATUS) |=> rd_data[4:0] == 5'h00)
    else $error("code reported with no source enabled");
  a_buf_pend_set:
    assert property (can_evt.buffer_done[0] ##1 !bus_req.wr
      ##1 (bus_req.rd && bus_req.addr == OFS_PENDING) |=> rd_data[0])
    else $error("buffer pending not set");
  a_err_pend_set:
    assert property (can_evt.error_change ##1 !bus_req.wr
      ##1 (bus_req.rd && bus_req.addr == OFS_PENDING) |=> rd_data[15])
    else $error("error pending not set");
  a_err_clear:
    assert property ((bus_req.wr && bus_req.addr == OFS_CLEAR && bus_req.wdata[15]
      && !can_evt.error_change)
      ##1 (!bus_req.wr && !can_evt.error_change)
      ##1 (bus_req.rd && bus_req.addr == OFS_PENDING && !can_evt.error_change) |=> !rd_data[15])
    else $error("error pending not cleared");
  a_node_bus_off:
    assert property ((node_in == 4'h1)[*3] ##0 (bus_req.rd && bus_req.addr == OFS_STATUS)
      |=> rd_data[10:8] == 3'h6)
    else $error("bus off state wrong");
  a_node_warning:
    assert property ((node_in == 4'h4)[*3] ##0 (bus_req.rd && bus_req.addr == OFS_STATUS)
      |=> rd_data[10:8] == 3'h3)
    else $error("warning state wrong");
  a_clear_reads:
    assert property (bus_req.rd && bus_req.addr == OFS_CLEAR |=> rd_data == 16'h0000)
    else $error("clear register read not zero");
endmodule // ciq_top_asserts

bind ciq_top ciq_top_asserts u_chk (.clk(clk), .reset(reset), .bus_req(bus_req),
  .rd_data(rd_data), .can_evt(can_evt), .node_in(node_in), .irq(irq));

// ===== tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ciq_pkg::*;
  logic         clk;
  logic         reset;
  ciq_bus_req_t bus_req;
  logic [15:0]  rd_data;
  ciq_can_evt_t can_evt;
  ciq_node_in_t node_in;
  logic         irq;
  logic [15:0]  rdv;
  int           errors = 0;
  int           checks_done = 0;
  int           cycles = 0;
  ciq_node_in_t ni [5] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1};
  logic [2:0]   ns [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6};

  ciq_top dut (.clk(clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
    .can_evt(can_evt), .node_in(node_in), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
  endtask
  task automatic rc(input logic [7:0] a, input string n, input logic [15:0] e);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    bus_req <= '0;
    #1 chk(n, e, rd_data);
  endtask
  task automatic ev(input ciq_can_evt_t e);
    @(posedge clk);
    can_evt <= e;
    @(posedge clk);
    can_evt <= '0;
  endtask
  task automatic wrap_up();
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Bounded run: the sequence needs under two hundred cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    reset = 1'b1;
    bus_req = '0;
    can_evt = '0;
    node_in = '0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rc(OFS_CODE_EN, "code_en rst", CODE_EN_RST);
    rc(OFS_STATUS, "status rst", 16'h0000);
    wr(OFS_CODE_EN, 16'hFFFF);
    rc(OFS_CODE_EN, "code_en", 16'hFFFF);
    rc(8'h20, "unmapped", 16'h0000);
    rc(OFS_CLEAR, "clear rd", 16'h0000);
    for (int i = 14; i >= 0; i--) begin
      ev('{error_change: 1'b0, buffer_done: 15'(1 << i)});
      rc(OFS_STATUS, "buf code", 16'h0010 | 16'(i + 1));
    end
    ev('{error_change: 1'b1, buffer_done: 15'h0001});
    rc(OFS_PENDING, "pending", 16'hFFFF);
    wr(OFS_PENDING, 16'h0000);
    rc(OFS_PENDING, "pending ro", 16'hFFFF);
    rc(OFS_STATUS, "err code", 16'h0010);
    wr(OFS_CODE_EN, 16'h7FFF);
    rc(OFS_STATUS, "err off", 16'h0011);
    wr(OFS_CODE_EN, 16'h4000);
    rc(OFS_STATUS, "buf14 only", 16'h001F);
    wr(OFS_CODE_EN, 16'h0000);
    rc(OFS_STATUS, "none on", 16'h0000);
    wr(OFS_CLEAR, 16'h0000);
    rc(OFS_PENDING, "clr zero", 16'hFFFF);
    wr(OFS_CLEAR, 16'h8001);
    rc(OFS_PENDING, "clr err", 16'h7FFE);
    wr(OFS_CODE_EN, 16'hFFFF);
    rc(OFS_STATUS, "after clr", 16'h0012);
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      node_in <= ni[k];
      repeat (3) @(posedge clk);
      rc(OFS_STATUS, "node", {5'h00, ns[k], 8'h12});
    end
    rc(OFS_INT_STAT, "int all", 16'h0007);
    wr(OFS_INT_STAT, 16'h0007);
    wr(OFS_INT_MASK, 16'h0002);
    rc(OFS_INT_MASK, "mask", 16'h0002);
    chk("irq idle", 16'h0000, {15'h0000, irq});
    ev('{error_change: 1'b0, buffer_done: 15'h0008});
    rc(OFS_INT_STAT, "int stat", 16'h0002);
    chk("irq on", 16'h0001, {15'h0000, irq});
    wr(OFS_INT_MASK, 16'h0001);
    rc(OFS_INT_MASK, "mask off", 16'h0001);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wr(OFS_INT_MASK, 16'h0002);
    wr(OFS_INT_STAT, 16'h0002);
    rc(OFS_INT_STAT, "stat clr", 16'h0000);
    chk("irq clr", 16'h0000, {15'h0000, irq});
    // A second reset in mid-run must clear the pending flags and the enables.
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rc(OFS_PENDING, "pending rst", 16'h0000);
    rc(OFS_CODE_EN, "code_en rst2", CODE_EN_RST);
    rc(OFS_STATUS, "status rst2", {5'h00, NS_BUS_OFF, 8'h00});
    wrap_up();
  end
endmodule // tb_top
